// [core/core_interrupt_control.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// (R1) Flags set on their source condition, regardless of any enable bit.
// (R2) Bit 7 global enable passes all unmasked interrupts; zero blocks all. The code gates only CORE_IRQ; EVENT_IRQ ignores bit 7.
// (R3) Bit 6 peripheral enable gates the combined peripheral request.
// (R4) Bit 5 enables the timer-zero overflow interrupt.
// (R5) Bit 4 enables the external pin interrupt.
// (R6) Bit 3 enables the port-change interrupt.
// (R7) Bit 2 timer-zero overflow flag set on overflow, cleared by software.
// (R8) Bit 1 external pin flag set on pin event, cleared by software.
// (R9) Bit 0 port-change flag set on upper port-B change, software clears.
// (R10) Mismatch keeps re-setting port-change flag; port-B read ends mismatch.
// (R11) All eight bits read/write; bits 7..1 reset to zero.
// (R12) Register reachable at four bank addresses, one physical register.
// (R13) Software should clear a flag before enabling its interrupt.
// (R14) Request = global AND (enabled flag pairs OR peripheral-enabled request).
// (R15) Change detect compares synced upper pins with values latched on read.
module core_interrupt_control
  import irq_ctrl_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       CE,
  input  wire logic [8:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       TIMER_ZERO_OVERFLOW,
  input  wire logic       EXT_IRQ_PIN,
  input  wire logic       EXT_EDGE_RISING,
  input  wire logic [3:0] UPPER_PORT_B_PINS,
  input  wire logic       PERIPH_REQ,
  output logic            CORE_IRQ,
  output logic            EVENT_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:3] enable_ff;
  logic       timer_flag_ff;
  logic       ext_flag_ff;
  logic       change_flag_ff;
  logic [7:0] ctrl_word;
  logic       timer_pair;
  logic       ext_pair;
  logic       change_pair;
  logic       periph_pair;
  logic       any_source;
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic       ext_meta_ff;
  logic       ext_sync_ff;
  logic       ext_prev_ff;
  logic [3:0] port_latch_ff;
  logic [2:0] event_status_ff;
  logic [2:0] event_mask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       ctrl_sel;
  logic       port_sel;
  logic       ctrl_wr;
  logic       ext_event;
  logic       mismatch;
  logic [2:0] event_set;

  // Bank aliasing decode, used by read and write paths
  function automatic logic is_ctrl_addr(input logic [8:0] a);
    return (a == IRQ_CTRL_ADDR_BANK0) || (a == IRQ_CTRL_ADDR_BANK1) ||
           (a == IRQ_CTRL_ADDR_BANK2) || (a == IRQ_CTRL_ADDR_BANK3);
  endfunction

  // Enable bit and flag bit of one source both set
  function automatic logic pair_active(input logic en, input logic flag);
    return en && flag;
  endfunction

  assign ctrl_sel = is_ctrl_addr(ADDR);                 // see (R12)
  assign port_sel = (ADDR == PORT_B_ADDR) || (ADDR == PORT_B_ADDR_BANK2);
  assign ctrl_wr  = WR && ctrl_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Upper port-B pin synchroniser, two stages before any logic
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_meta_ff <= PORT_LATCH_RESET;
      pin_sync_ff <= PORT_LATCH_RESET;
    end else if (CE) begin
      pin_meta_ff <= UPPER_PORT_B_PINS;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // External pin synchroniser plus one stage for edge detection
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else if (CE) begin
      ext_meta_ff <= EXT_IRQ_PIN;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  // External edge, polarity chosen by the caller
  assign ext_event = EXT_EDGE_RISING ? (ext_sync_ff && !ext_prev_ff)
                                     : (!ext_sync_ff && ext_prev_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Port-B read latches pins and ends the mismatch
  always_ff @(posedge CLK) begin
    if (RESET) begin
      port_latch_ff <= PORT_LATCH_RESET;
    end else if (CE && RD && port_sel) begin
      port_latch_ff <= pin_sync_ff;                     // see (R10)
    end
  end

  assign mismatch = |(pin_sync_ff ^ port_latch_ff);     // see (R15)

  ////////////////////////////////////////////////////////////////////////////
  // Enable bits, plain software state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      enable_ff <= IRQ_CTRL_RESET[GLOBAL_EN_BIT:CHANGE_EN_BIT];    // see (R11)
    end else if (CE && ctrl_wr) begin
      enable_ff <= WDATA[GLOBAL_EN_BIT:CHANGE_EN_BIT];             // see (R11)
    end
  end

  // Timer-zero flag: overflow sets, software write loses to a set
  always_ff @(posedge CLK) begin
    if (RESET) begin
      timer_flag_ff <= IRQ_CTRL_RESET[TIMER_ZERO_FLAG_BIT];
    end else if (CE) begin
      if (TIMER_ZERO_OVERFLOW) begin
        timer_flag_ff <= 1'b1;                          // see (R1) see (R7)
      end else if (ctrl_wr) begin
        timer_flag_ff <= WDATA[TIMER_ZERO_FLAG_BIT];    // see (R11)
      end
    end
  end

  // External pin flag: chosen edge sets, software write loses to a set
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_flag_ff <= IRQ_CTRL_RESET[EXT_FLAG_BIT];
    end else if (CE) begin
      if (ext_event) begin
        ext_flag_ff <= 1'b1;                            // see (R1) see (R8)
      end else if (ctrl_wr) begin
        ext_flag_ff <= WDATA[EXT_FLAG_BIT];             // see (R11)
      end
    end
  end

  // Port-change flag: re-set every cycle while the mismatch lasts
  always_ff @(posedge CLK) begin
    if (RESET) begin
      change_flag_ff <= IRQ_CTRL_RESET[CHANGE_FLAG_BIT];
    end else if (CE) begin
      if (mismatch) begin
        change_flag_ff <= 1'b1;                         // see (R9) see (R10)
      end else if (ctrl_wr) begin
        change_flag_ff <= WDATA[CHANGE_FLAG_BIT];       // see (R11)
      end
    end
  end

  // Register image as software sees it
  assign ctrl_word = {enable_ff, timer_flag_ff, ext_flag_ff, change_flag_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request to the core
  assign timer_pair  = pair_active(enable_ff[TIMER_ZERO_EN_BIT], timer_flag_ff);   // see (R4)
  assign ext_pair    = pair_active(enable_ff[EXT_EN_BIT], ext_flag_ff);            // see (R5)
  assign change_pair = pair_active(enable_ff[CHANGE_EN_BIT], change_flag_ff);      // see (R6)
  assign periph_pair = pair_active(enable_ff[PERIPH_EN_BIT], PERIPH_REQ);          // see (R3)
  assign any_source  = timer_pair || ext_pair || change_pair || periph_pair;       // see (R14)
  assign CORE_IRQ    = enable_ff[GLOBAL_EN_BIT] && any_source;                     // see (R2)

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event status, write-one-to-clear, with mask
  assign event_set = {mismatch, ext_event, TIMER_ZERO_OVERFLOW};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      event_status_ff <= EVENT_RESET;
    end else if (CE) begin
      if (WR && (ADDR == EVENT_STATUS_ADDR)) begin
        event_status_ff <= (event_status_ff & ~WDATA[2:0]) | event_set;
      end else begin
        event_status_ff <= event_status_ff | event_set;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      event_mask_ff <= EVENT_RESET;
    end else if (CE && WR && (ADDR == EVENT_MASK_ADDR)) begin
      event_mask_ff <= WDATA[2:0];
    end
  end

  assign EVENT_IRQ = |(event_status_ff & event_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, data one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (ctrl_sel) begin
      nxt_rdata = ctrl_word;                            // see (R12)
    end else if (port_sel) begin
      nxt_rdata = {pin_sync_ff, 4'h0};
    end else if (ADDR == EVENT_STATUS_ADDR) begin
      nxt_rdata = {5'h00, event_status_ff};
    end else if (ADDR == EVENT_MASK_ADDR) begin
      nxt_rdata = {5'h00, event_mask_ff};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else if (CE) begin
      rdata_ff <= RD ? nxt_rdata : 8'h00;
    end
  end

  assign RDATA = rdata_ff;

endmodule // core_interrupt_control

// [core/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // Register map: one control register aliased in four banks
  localparam logic [8:0] IRQ_CTRL_ADDR_BANK0 = 9'h00b;
  localparam logic [8:0] IRQ_CTRL_ADDR_BANK1 = 9'h08b;
  localparam logic [8:0] IRQ_CTRL_ADDR_BANK2 = 9'h10b;
  localparam logic [8:0] IRQ_CTRL_ADDR_BANK3 = 9'h18b;
  // Port-B data register, read side effect latches the pins
  localparam logic [8:0] PORT_B_ADDR         = 9'h006;
  localparam logic [8:0] PORT_B_ADDR_BANK2   = 9'h106;
  // Interrupt status / mask registers for the timer overflow, external edge and port-change events
  localparam logic [8:0] EVENT_STATUS_ADDR   = 9'h1f0;
  localparam logic [8:0] EVENT_MASK_ADDR     = 9'h1f1;

  // Field positions
  localparam int GLOBAL_EN_BIT   = 7;
  localparam int PERIPH_EN_BIT   = 6;
  localparam int TIMER_ZERO_EN_BIT   = 5;
  localparam int EXT_EN_BIT      = 4;
  localparam int CHANGE_EN_BIT   = 3;
  localparam int TIMER_ZERO_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT    = 1;
  localparam int CHANGE_FLAG_BIT = 0;

  // Reset values; port-change flag is undefined, modelled as zero
  localparam logic [7:0] IRQ_CTRL_RESET   = 8'h00;
  localparam logic [2:0] EVENT_RESET      = 3'h0;
  localparam logic [3:0] PORT_LATCH_RESET = 4'h0;

endpackage

// [testbench/core_interrupt_control_bench.sv]
`timescale 1ns/1ps
module core_interrupt_control_bench;
  import irq_ctrl_pkg::*;
  logic       CLK = 0, RESET = 1, CE = 1, WR = 0, RD = 0, TIMER_ZERO_OVERFLOW = 0;
  logic       EXT_IRQ_PIN = 0, EXT_EDGE_RISING = 1, PERIPH_REQ, CORE_IRQ, EVENT_IRQ;
  logic [8:0] ADDR = 9'h000;
  logic [7:0] WDATA = 8'h00, RDATA, d;
  logic [3:0] UPPER_PORT_B_PINS = 4'h0;
  logic [8:0] bk [4] = '{IRQ_CTRL_ADDR_BANK0, IRQ_CTRL_ADDR_BANK1,
                         IRQ_CTRL_ADDR_BANK2, IRQ_CTRL_ADDR_BANK3};
  logic [7:0] fix [4] = '{8'ha4, 8'hc0, 8'h80, 8'h24};
  int         num_errors = 0, comparisons = 0, seed = 46994;
  always #4 CLK = ~CLK;
  core_interrupt_control core_interrupt_control_i (.*);
  periph_source periph_source_i (.CLK(CLK), .RESET(RESET), .REQ(PERIPH_REQ));
  ////////////////////////////////////////////////////////////////////////////
  // One bus slot, driven right after the edge
  task automatic bus(logic w, r, t, logic [8:0] a, logic [7:0] v);
    @(posedge CLK);
    WR <= w;
    RD <= r;
    TIMER_ZERO_OVERFLOW <= t;
    ADDR <= a;
    WDATA <= v;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h got %h", n, e, g);
    end
  endtask
  // Single-bit level results
  task automatic chk_level(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] v);
    bus(1'h1, 1'h0, 1'h0, a, v);
  endtask
  // Data stands only in the slot after the read
  task automatic rd(logic [8:0] a, logic [7:0] e);
    bus(1'h0, 1'h1, 1'h0, a, 8'h00);
    bus(1'h0, 1'h0, 1'h0, a, 8'h00);
    #1 chk("rdata", e, RDATA);
  endtask
  function automatic logic exp_irq(logic [7:0] c, logic p);
    return c[7] & (c[5] & c[2] | c[4] & c[1] | c[3] & c[0] | c[6] & p);
  endfunction
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'h0;
    rd(IRQ_CTRL_ADDR_BANK0, 8'h00);
    for (int i = 0; i < 20; i++) begin
      d = (i < 4) ? fix[i] : 8'($random(seed));
      wr(bk[i % 4], d);
      rd(bk[(i + 1) % 4], d);
      chk_level("irq", exp_irq(d, PERIPH_REQ), CORE_IRQ);
    end
    bus(1'h1, 1'h0, 1'h1, IRQ_CTRL_ADDR_BANK0, 8'h00);
    rd(IRQ_CTRL_ADDR_BANK0, 8'h04);
    wr(IRQ_CTRL_ADDR_BANK0, 8'h00);
    EXT_IRQ_PIN <= 1'h1;
    repeat (4) bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    rd(IRQ_CTRL_ADDR_BANK0, 8'h02);
    UPPER_PORT_B_PINS <= 4'h5;
    repeat (4) bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    wr(IRQ_CTRL_ADDR_BANK0, 8'h00);
    rd(IRQ_CTRL_ADDR_BANK0, 8'h01);
    rd(PORT_B_ADDR, 8'h50);
    wr(IRQ_CTRL_ADDR_BANK0, 8'h00);
    rd(IRQ_CTRL_ADDR_BANK0, 8'h00);
    // Clock enable low: write and overflow both ignored
    CE <= 1'h0;
    bus(1'h1, 1'h0, 1'h1, IRQ_CTRL_ADDR_BANK1, 8'hff);
    bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    CE <= 1'h1;
    rd(IRQ_CTRL_ADDR_BANK0, 8'h00);
    // Falling-edge mode on the external pin
    EXT_EDGE_RISING <= 1'h0;
    EXT_IRQ_PIN <= 1'h0;
    repeat (4) bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    rd(IRQ_CTRL_ADDR_BANK0, 8'h02);
    wr(EVENT_MASK_ADDR, 8'h04);
    bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    #1 chk_level("event_irq", 1'h1, EVENT_IRQ);
    wr(EVENT_STATUS_ADDR, 8'h07);
    bus(1'h0, 1'h0, 1'h0, 9'h000, 8'h00);
    #1 chk_level("event_irq", 1'h0, EVENT_IRQ);
    wr(EVENT_MASK_ADDR, 8'h00);
    rd(9'h1ff, 8'h00);
    report_and_stop;
  end
  // Watchdog against a hung run
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
endmodule // core_interrupt_control_bench

// [testbench/irq_ctrl_assertions.sv]
`timescale 1ns/1ps
module irq_ctrl_checker
  import irq_ctrl_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       CE,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic       TIMER_ZERO_OVERFLOW,
  input wire logic       PERIPH_REQ,
  input wire logic       EXT_IRQ_PIN,
  input wire logic       EXT_EDGE_RISING,
  input wire logic       CORE_IRQ,
  input wire logic       EVENT_IRQ,
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic [3:0] UPPER_PORT_B_PINS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Bus answers and request gating
  a_rdata_idle: assert property (CE && !RD |=> RDATA == 8'h00)
    else $error("read data outside read slot");
  a_tmr_flag_set: assert property (CE && TIMER_ZERO_OVERFLOW ##1
    (CE && RD && ADDR == IRQ_CTRL_ADDR_BANK0) |=> RDATA[TIMER_ZERO_FLAG_BIT])
    else $error("timer flag lost");
  a_global_block: assert property (CE && WR && ADDR[6:0] == 7'h0b &&
    !WDATA[GLOBAL_EN_BIT] |=> !CORE_IRQ) else $error("request with global off");
  a_periph_gate: assert property (CE && WR && ADDR[6:0] == 7'h0b &&
    WDATA == 8'hc0 |=> CORE_IRQ == PERIPH_REQ) else $error("peripheral path wrong");
  a_periph_mask: assert property (CE && WR && ADDR[6:0] == 7'h0b &&
    WDATA == 8'h80 |=> !CORE_IRQ) else $error("request with sources off");
  a_flag_enable: assert property (CE && WR && ADDR[6:0] == 7'h0b &&
    WDATA == 8'ha4 |=> CORE_IRQ) else $error("enabled timer flag ignored");
  a_bank_alias: assert property (CE && WR && ADDR == IRQ_CTRL_ADDR_BANK3 ##1
    (CE && RD && ADDR == IRQ_CTRL_ADDR_BANK0) |=> RDATA[7:3] == $past(WDATA[7:3], 2))
    else $error("bank alias mismatch");
  a_event_mask: assert property (CE && WR && ADDR == EVENT_MASK_ADDR &&
    WDATA == 8'h00 |=> !EVENT_IRQ) else $error("masked event interrupt");
  c_irq_seen: cover property (CORE_IRQ);
  c_event_seen: cover property (EVENT_IRQ);
  c_timer_read: cover property (TIMER_ZERO_OVERFLOW ##1 RD);
endmodule // irq_ctrl_checker
bind core_interrupt_control irq_ctrl_checker irq_ctrl_checker_i (.*);

// [testbench/periph_source.sv]
`timescale 1ns/1ps
module periph_source (
  input  wire logic CLK,
  input  wire logic RESET,
  output logic      REQ
);
  int seed = 46994;
  // Combined peripheral request, random level each cycle
  always @(posedge CLK) begin
    REQ <= RESET ? 1'h0 : 1'($random(seed));
  end
endmodule // periph_source
